// *** logic/catc_pkg.sv ***
// Purpose: shared constants for the cell trim correction block
// Assumes: 100 MHz core clock, 16-bit unsigned conversion codes
// Notes:   register offsets are word addresses on the plain register port
package catc_pkg;
  // register map
  localparam logic [3:0] ADDR_GAIN     = 4'h0;
  localparam logic [3:0] ADDR_OFFSET   = 4'h1;
  localparam logic [3:0] ADDR_CTRL     = 4'h2;
  localparam logic [3:0] ADDR_CHAN_EN  = 4'h3;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_RESULT   = 4'h5;
  // field positions and reset values
  localparam int         CTRL_HOLD_BIT   = 0;
  localparam logic [7:0] GAIN_RESET      = 8'h00;
  localparam logic [7:0] OFFSET_RESET    = 8'h00;
  localparam logic [15:0] CHAN_EN_RESET  = 16'hFFFF;
  localparam logic [15:0] CODE_MAX       = 16'hFFFF;
  // timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int HOLD_DELAY_US  = 100;
  localparam int HOLD_DELAY_CYC = (HOLD_DELAY_US * 1000) / CLK_PERIOD_NS;
  // sampler states, gray coded along idle -> wait -> convert
  typedef enum logic [1:0] {
    CATC_IDLE = 2'b00,
    CATC_WAIT = 2'b01,
    CATC_CONV = 2'b11
  } catc_state_type;
endpackage

// *** logic/catc_trim_if.sv ***
// Purpose: carries one raw code and its corrected result between modules
// Assumes: single clock domain
// Notes:   corrected value is combinational from the trims and the code
`timescale 1ns/100ps
interface catc_trim_if;
  logic        clk;
  logic [15:0] raw_code;
  logic        is_cell;
  logic [7:0]  gain_trim_value;
  logic [7:0]  offset_trim_value;
  logic [15:0] corrected;
  modport user (output clk, output raw_code, output is_cell, output gain_trim_value,
                output offset_trim_value, input corrected);
  modport calc (input clk, input raw_code, input is_cell, input gain_trim_value,
                input offset_trim_value, output corrected);
endinterface

// *** logic/catc_trim_calc.sv ***
// Purpose: applies the signed gain and offset trims to a cell code
// Assumes: raw code already carries the factory corrections
// Notes:   gain step is one code at full scale, scaled by code/2^16
`timescale 1ns/100ps
module catc_trim_calc (
  catc_trim_if.calc t
);
  logic signed [25:0] gain_prod;
  logic signed [18:0] gain_term;
  logic signed [18:0] sum;
  logic [15:0]        clamped;

  // gain term grows with the input level: full scale gives the whole step
  assign gain_prod = $signed(t.gain_trim_value) * $signed({1'b0, t.raw_code});
  assign gain_term = 19'(gain_prod >>> 16);
  // offset is added flat whatever the level
  assign sum = $signed({3'b000, t.raw_code}) + gain_term
               + 19'($signed(t.offset_trim_value));
  // clamp so that a trim never wraps the code
  assign clamped = sum[18] ? 16'h0000 :
                   (sum > $signed({3'b000, catc_pkg::CODE_MAX})) ? catc_pkg::CODE_MAX :
                   sum[15:0];
  // aux codes pass through untouched
  assign t.corrected = t.is_cell ? clamped : t.raw_code;

  zero_trim_a: assert property (@(posedge t.clk)
    (t.gain_trim_value == 8'h00 && t.offset_trim_value == 8'h00)
      |-> t.corrected == t.raw_code) else $error("zero trims changed the code");
  aux_pass_a: assert property (@(posedge t.clk)
    !t.is_cell |-> t.corrected == t.raw_code) else $error("aux code altered");
endmodule

// *** logic/catc_core.sv ***
// Purpose: conversion correction and channel parking for the cell sense adc
// Assumes: converter results arrive already factory corrected
// Notes:   registers on a plain port, read data one cycle after the strobe
`timescale 1ns/100ps
module catc_core #(
  parameter int HOLD_CYCLES = catc_pkg::HOLD_DELAY_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        sample_req,
  output logic             adc_start,
  input  wire logic        adc_done,
  input  wire logic [15:0] adc_code,
  input  wire logic        adc_is_cell,
  output logic [15:0]      result_code,
  output logic             result_valid,
  output logic [3:0]       mux_sel,
  output logic             mux_park
);
  initial begin
    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 1048575) $error("HOLD_CYCLES out of range");
  end

  catc_pkg::catc_state_type state_reg, state_next;
  logic [7:0]  gain_reg;
  logic [7:0]  offset_reg;
  logic [15:0] chan_en_reg;
  logic        hold_req_reg;
  logic        hold_act_reg;
  logic [19:0] wait_cnt_reg;
  logic [15:0] result_reg;
  logic        valid_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rd_mux;
  logic [3:0]  park_chan;
  logic        wr_gain, wr_off, wr_ctrl, wr_chan;

  catc_trim_if trim ();
  catc_trim_calc u_calc (.t(trim));

  // converter code is already factory corrected; user trims go on top
  assign trim.clk               = core_clk;
  assign trim.raw_code          = adc_code;
  assign trim.is_cell           = adc_is_cell;
  assign trim.gain_trim_value   = gain_reg;
  assign trim.offset_trim_value = offset_reg;

  // highest enabled channel wins the park position
  function automatic logic [3:0] top_chan(input logic [15:0] en);
    top_chan = 4'hF;
    for (int i = 0; i < 16; i++) begin
      if (en[i]) top_chan = 4'(i);
    end
  endfunction

  assign park_chan = top_chan(chan_en_reg);
  assign mux_sel   = park_chan;
  assign mux_park  = (state_reg == catc_pkg::CATC_IDLE);

  // write decode
  assign wr_gain = reg_wr && reg_addr == catc_pkg::ADDR_GAIN;
  assign wr_off  = reg_wr && reg_addr == catc_pkg::ADDR_OFFSET;
  assign wr_ctrl = reg_wr && reg_addr == catc_pkg::ADDR_CTRL;
  assign wr_chan = reg_wr && reg_addr == catc_pkg::ADDR_CHAN_EN;

  // read decode; unmapped addresses read zero
  assign rd_mux =
    (reg_addr == catc_pkg::ADDR_GAIN)    ? {8'h00, gain_reg} :
    (reg_addr == catc_pkg::ADDR_OFFSET)  ? {8'h00, offset_reg} :
    (reg_addr == catc_pkg::ADDR_CTRL)    ? {15'h0000, hold_req_reg} :
    (reg_addr == catc_pkg::ADDR_CHAN_EN) ? chan_en_reg :
    (reg_addr == catc_pkg::ADDR_STATUS)  ? {10'h000, park_chan, hold_act_reg,
                                             state_reg != catc_pkg::CATC_IDLE} :
    (reg_addr == catc_pkg::ADDR_RESULT)  ? result_reg : 16'h0000;

  // register writes; trims are stored raw as signed bytes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gain_reg     <= catc_pkg::GAIN_RESET;
      offset_reg   <= catc_pkg::OFFSET_RESET;
      chan_en_reg  <= catc_pkg::CHAN_EN_RESET;
      hold_req_reg <= 1'b0;
    end else begin
      if (wr_gain) gain_reg <= reg_wdata[7:0];
      if (wr_off) offset_reg <= reg_wdata[7:0];
      if (wr_chan) chan_en_reg <= reg_wdata;
      if (wr_ctrl) hold_req_reg <= reg_wdata[catc_pkg::CTRL_HOLD_BIT];
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (rst) rdata_reg <= 16'h0000;
    else rdata_reg <= reg_rd ? rd_mux : 16'h0000;
  end
  assign reg_rdata = rdata_reg;

  // sampler state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      catc_pkg::CATC_IDLE: begin
        if (sample_req) state_next = hold_act_reg ? catc_pkg::CATC_WAIT
                                                  : catc_pkg::CATC_CONV;
      end
      catc_pkg::CATC_WAIT: begin
        if (wait_cnt_reg == 20'(HOLD_CYCLES - 1)) state_next = catc_pkg::CATC_CONV;
      end
      catc_pkg::CATC_CONV: begin
        if (adc_done) state_next = catc_pkg::CATC_IDLE;
      end
      default: state_next = catc_pkg::CATC_IDLE;
    endcase
  end

  // a start pulse on entry to convert
  assign adc_start = (state_reg != catc_pkg::CATC_CONV) &&
                     (state_next == catc_pkg::CATC_CONV);

  always_ff @(posedge core_clk) begin
    if (rst) state_reg <= catc_pkg::CATC_IDLE;
    else state_reg <= state_next;
  end

  // delay counter runs only while waiting
  always_ff @(posedge core_clk) begin
    if (rst || state_reg != catc_pkg::CATC_WAIT) wait_cnt_reg <= 20'h00000;
    else wait_cnt_reg <= wait_cnt_reg + 20'h00001;
  end

  // hold bit copied only when a sample completes, so chained parts stay aligned
  always_ff @(posedge core_clk) begin
    if (rst) hold_act_reg <= 1'b0;
    else if (state_reg == catc_pkg::CATC_CONV && adc_done) hold_act_reg <= hold_req_reg;
  end

  // corrected result captured on completion
  always_ff @(posedge core_clk) begin
    if (rst) begin
      result_reg <= 16'h0000;
      valid_reg  <= 1'b0;
    end else begin
      valid_reg <= state_reg == catc_pkg::CATC_CONV && adc_done;
      if (state_reg == catc_pkg::CATC_CONV && adc_done) result_reg <= trim.corrected;
    end
  end
  assign result_code  = result_reg;
  assign result_valid = valid_reg;

  // assertions
  sequence s_req_held;
    state_reg == catc_pkg::CATC_IDLE && sample_req && hold_act_reg;
  endsequence
  sequence s_req_free;
    state_reg == catc_pkg::CATC_IDLE && sample_req && !hold_act_reg;
  endsequence

  hold_delay_a: assert property (@(posedge core_clk) disable iff (rst)
    s_req_held |=> (!adc_start && state_reg == catc_pkg::CATC_WAIT)[*8])
    else $error("held sample started too early");
  hold_count_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == catc_pkg::CATC_WAIT) |-> wait_cnt_reg < 20'(HOLD_CYCLES))
    else $error("hold counter overran");
  free_start_a: assert property (@(posedge core_clk) disable iff (rst)
    s_req_free |-> adc_start ##1 state_reg == catc_pkg::CATC_CONV)
    else $error("unheld request did not start");
  hold_apply_a: assert property (@(posedge core_clk) disable iff (rst)
    $changed(hold_act_reg) |-> $past(state_reg) == catc_pkg::CATC_CONV && $past(adc_done))
    else $error("hold bit applied outside sample end");
  park_chan_a: assert property (@(posedge core_clk) disable iff (rst)
    (chan_en_reg != 16'h0000) |-> chan_en_reg[mux_sel] &&
      ((chan_en_reg >> mux_sel) == 16'h0001))
    else $error("park channel not highest enabled");
  result_aux_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == catc_pkg::CATC_CONV && adc_done && !adc_is_cell)
      |=> result_valid && result_code == $past(adc_code))
    else $error("aux result was trimmed");
  zero_trim_core_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == catc_pkg::CATC_CONV && adc_done && gain_reg == 8'h00 && offset_reg == 8'h00)
      |=> result_code == $past(adc_code))
    else $error("zero trims altered result");
  offset_flat_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == catc_pkg::CATC_CONV && adc_done && adc_is_cell && gain_reg == 8'h00
      && adc_code == 16'h8000)
      |=> result_code == 16'(17'h08000 + 17'($signed($past(offset_reg)))))
    else $error("offset not added flat");
endmodule

// *** sim/catc_adc_model.sv ***
// Purpose: converter model answering start pulses after a fixed latency
// Assumes: codes handed over already carry the factory corrections
// Notes:   outside the done cycle the code lines show the inverse value
`timescale 1ns/100ps
module catc_adc_model #(
  parameter int LAT = 4
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        adc_start,
  input  wire logic [15:0] code_in,
  input  wire logic        cell_in,
  output logic             adc_done,
  output logic [15:0]      adc_code,
  output logic             adc_is_cell
);
  int cnt_reg;
  // conversion latency count, one done pulse per start
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg  <= 0;
      adc_done <= 1'b0;
    end else begin
      adc_done <= (cnt_reg == 1);
      if (adc_start)
        cnt_reg <= LAT;
      else if (cnt_reg != 0)
        cnt_reg <= cnt_reg - 1;
    end
  end
  // stale lines flip so a late sample cannot pass by luck
  assign adc_code    = adc_done ? code_in : ~code_in;
  assign adc_is_cell = adc_done ? cell_in : ~cell_in;
endmodule

// *** sim/tb_catc_core.sv ***
// Purpose: register, parking, trim and hold checks for the correction core
// Assumes: hold delay shortened to 20 cycles
// Notes:   hold delay accepted at 20 or 21 cycles from request
`timescale 1ns/100ps
module tb_catc_core;
  localparam int HC = 20;
  logic        core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sample_req = 0, cell_in = 1;
  logic [3:0]  reg_addr = 4'h0, mux_sel;
  logic [15:0] reg_wdata = 16'h0000, code_in = 16'h0000, rdata, result_code, adc_code;
  logic        adc_start, adc_done, adc_is_cell, result_valid, mux_park;
  int          err_count = 0, n_tests = 0, cyc = 0, wt, i;
  // trims as a host would derive them from two points inside 2.0 V to 4.5 V
  logic [32:0] tbl [7] = '{{1'b1, 8'h00, 8'h00, 16'h8000}, {1'b1, 8'h7F, 8'h00, 16'hF000},
    {1'b1, 8'h7F, 8'h00, 16'h7800}, {1'b1, 8'h80, 8'h7F, 16'h4000},
    {1'b1, 8'h00, 8'h80, 16'h0010}, {1'b1, 8'h7F, 8'h7F, 16'hFFF0},
    {1'b0, 8'h7F, 8'h7F, 16'h1234}};
  always #5 core_clk = ~core_clk;
  catc_core #(.HOLD_CYCLES(HC)) u_catc_core (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .sample_req(sample_req), .adc_start(adc_start),
    .adc_done(adc_done), .adc_code(adc_code), .adc_is_cell(adc_is_cell),
    .result_code(result_code), .result_valid(result_valid), .mux_sel(mux_sel),
    .mux_park(mux_park));
  catc_adc_model u_catc_adc_model (.core_clk(core_clk), .rst(rst), .adc_start(adc_start),
    .code_in(code_in), .cell_in(cell_in), .adc_done(adc_done), .adc_code(adc_code),
    .adc_is_cell(adc_is_cell));
  // expected result: scaled gain term, flat offset, clamped to 16 bits
  function automatic logic [15:0] fix(input logic [15:0] c, input logic [7:0] g, o);
    logic signed [31:0] s;
    s = $signed({16'h0000, c}) + (($signed(g) * $signed({1'b0, c})) >>> 16) + $signed(o);
    if (s < 0) return 16'h0000;
    if (s > 32'sd65535) return 16'hFFFF;
    return s[15:0];
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(rdata, exp);
  endtask
  // one sampling request; h says whether the hold delay is expected
  task automatic conv(input logic [15:0] c, input logic cl, h, input logic [15:0] exp);
    @(posedge core_clk);
    sample_req <= 1'b1;
    code_in    <= c;
    cell_in    <= cl;
    @(negedge core_clk);
    for (wt = 0; wt < 100 && adc_start !== 1'b1; wt++) begin
      @(posedge core_clk);
      sample_req <= 1'b0;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    sample_req <= 1'b0;
    chk({15'h0000, h ? (wt >= HC && wt <= HC + 1) : (wt == 0)}, 16'h0001);
    for (i = 0; i < 50 && result_valid !== 1'b1; i++) @(negedge core_clk);
    chk(result_code, exp);
  endtask
  task automatic results;
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(catc_pkg::ADDR_GAIN, 16'h0000);
    rd(catc_pkg::ADDR_OFFSET, 16'h0000);
    rd(catc_pkg::ADDR_CHAN_EN, 16'hFFFF);
    rd(catc_pkg::ADDR_STATUS, 16'h003C);
    wr(4'hF, 16'h00FF);
    rd(4'hF, 16'h0000);
    @(negedge core_clk);
    chk({11'h000, mux_park, mux_sel}, 16'h001F);
    wr(catc_pkg::ADDR_CHAN_EN, 16'h00A5);
    @(negedge core_clk);
    chk({12'h000, mux_sel}, 16'h0007);
    wr(catc_pkg::ADDR_CHAN_EN, 16'hFFFF);
    for (int k = 0; k < 7; k++) begin
      wr(catc_pkg::ADDR_GAIN, {8'h00, tbl[k][31:24]});
      wr(catc_pkg::ADDR_OFFSET, {8'h00, tbl[k][23:16]});
      rd(catc_pkg::ADDR_GAIN, {8'h00, tbl[k][31:24]});
      rd(catc_pkg::ADDR_OFFSET, {8'h00, tbl[k][23:16]});
      conv(tbl[k][15:0], tbl[k][32], 1'b0, tbl[k][32] ? fix(tbl[k][15:0], tbl[k][31:24],
        tbl[k][23:16]) : tbl[k][15:0]);
    end
    wr(catc_pkg::ADDR_CTRL, 16'h0001);
    rd(catc_pkg::ADDR_CTRL, 16'h0001);
    conv(16'h2000, 1'b1, 1'b0, fix(16'h2000, 8'h7F, 8'h7F));
    rd(catc_pkg::ADDR_STATUS, 16'h003E);
    conv(16'h3000, 1'b1, 1'b1, fix(16'h3000, 8'h7F, 8'h7F));
    wr(catc_pkg::ADDR_CTRL, 16'h0000);
    conv(16'h3000, 1'b1, 1'b1, fix(16'h3000, 8'h7F, 8'h7F));
    conv(16'h4000, 1'b1, 1'b0, fix(16'h4000, 8'h7F, 8'h7F));
    rd(catc_pkg::ADDR_RESULT, fix(16'h4000, 8'h7F, 8'h7F));
    results();
  end
endmodule
